/* hw/cmv_pkg.sv */
// Constants, field layouts and carrier types for the processor configuration and mode vector block.
// Assumes a single 125 MHz core clock and an active-low asynchronous system reset.
package cmv_pkg;

  localparam int DATA_W = 32;
  localparam int NUM_INT = 6;

  // Field positions
  localparam int LOCK_BIT = 31;
  localparam int SLOW_BUS_BIT = 30;
  localparam int REFILL_BIT = 29;
  localparam int FLOAT_EXCEPTION_IRQ_SELECT_HI = 28;
  localparam int FLOAT_EXCEPTION_IRQ_SELECT_LO = 26;
  localparam int HALT_BIT = 25;
  localparam int RED_FREQ_BIT = 24;
  localparam int ALT_CACHE_BIT = 23;
  localparam int RESERVED_W = 23;

  // Reset values
  localparam logic [2:0] FLOAT_EXCEPTION_IRQ_SELECT_RESET = 3'h3;
  localparam logic [RESERVED_W-1:0] RESERVED_VAL = 23'h000000;

  // Mode vector pin positions on the interrupt inputs
  localparam int MV_TRISTATE = 0;
  localparam int MV_BYTE_ORDER = 1;
  localparam int MV_REFILL = 2;
  localparam int MV_COH_DMA = 3;
  localparam int MV_CLK_1X = 4;
  localparam int MV_HALF_BUS = 5;

  // Cache organization sizes in kB per cache
  localparam logic [3:0] CACHE_KB_ALT = 4'h8;
  localparam logic [3:0] CACHE_KB_STD = 4'h4;

  // Refill sizes in words
  localparam logic [2:0] REFILL_BLOCK = 3'h4;
  localparam logic [2:0] REFILL_SINGLE = 3'h1;

  // Frequency reduction
  localparam int RED_FREQ_DIV = 16;
  localparam logic [3:0] DIV_LAST = 4'(RED_FREQ_DIV - 1);

  // Bus turnaround timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TURN_FAST_NS = 15;
  localparam int TURN_SLOW_NS = 45;
  localparam logic [2:0] TURN_FAST_CYC = 3'((TURN_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] TURN_SLOW_CYC = 3'((TURN_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic lock;
    logic slowBus;
    logic blockRefill;
    logic [2:0] fpIntSel;
    logic halt;
    logic redFreq;
    logic altCache;
  } cmv_cfg_s;

  typedef struct packed {
    logic triState;
    logic byte_order_select;
    logic refillInit;
    logic cohDmaEn;
    logic clk1x;
    logic halfBus;
  } cmv_mode_s;

  typedef enum logic [1:0] {
    TURN_IDLE = 2'b00,
    TURN_WAIT = 2'b01,
    TURN_GO = 2'b10
  } cmv_turn_e;

endpackage

/* hw/cmv_clk_div.sv */
// Operating-frequency divider producing execution ticks and the board clock output.
// Assumes the core clock domain; the divide request comes from a core register.
`timescale 1ns/1ps
`default_nettype none
module cmv_clk_div (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic redFreq,
  input wire logic halfBus,
  output logic execTick,
  output logic busTick,
  output logic boardClk
);

  logic [3:0] divCnt_q, divCnt_d;
  logic boardClk_q, boardClk_d;
  logic busPhase_q, busPhase_d;

  always_comb begin
    divCnt_d = redFreq ? divCnt_q + 4'h1 : 4'h0;
    execTick = !redFreq || (divCnt_q == cmv_pkg::DIV_LAST);
    busTick = execTick && (!halfBus || busPhase_q);
    busPhase_d = execTick ? !busPhase_q : busPhase_q;
    boardClk_d = busTick ? !boardClk_q : boardClk_q;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_q <= 4'h0;
      boardClk_q <= 1'b0;
      busPhase_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      boardClk_q <= boardClk_d;
      busPhase_q <= busPhase_d;
    end
  end

  assign boardClk = boardClk_q;

  a_rf_tick_gap: assert property (@(posedge core_clk) disable iff (!nrst)
    (redFreq && execTick) |=> (redFreq ? !execTick : 1'b1) [*8])
    else $error("reduced frequency tick came too early");

endmodule
`default_nettype wire

/* hw/cmv_config_top.sv */
// Configuration register, reset mode vectors, interrupt routing, halt and bus turnaround.
// Assumes coprocessor register moves arrive as single-cycle strobes synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module cmv_config_top #(
  parameter bit CFG_PRESENT = 1'b1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  input wire logic [5:0] intPinLvl,
  input wire logic floatExcReq,
  input wire logic floatCmpResult,
  input wire logic turnReq,
  output logic turnGo,
  output logic [5:0] cpuIntReq,
  output logic coprocOneCond,
  output logic execStall,
  output logic execTick,
  output logic busTick,
  output logic boardClk,
  output logic [2:0] refillWords,
  output logic [3:0] cacheKb,
  output logic byte_order_select,
  output logic cohDmaEn,
  output logic clk1x,
  output logic halfBus,
  output logic pinOutEn,
  output logic captureDone
);

  cmv_pkg::cmv_cfg_s cfg_q, cfg_d;
  cmv_pkg::cmv_mode_s mode_q, mode_d;
  logic capture_q, capture_d;
  logic [31:0] rdData_q, rdData_d;
  cmv_pkg::cmv_turn_e turn_q, turn_d;
  logic [2:0] turnCnt_q, turnCnt_d;
  logic [5:0] fpMask;
  logic anyInt;
  logic divTick;

  function automatic logic [5:0] fpDecode(input logic [2:0] sel);
    logic [7:0] oneHot;
    oneHot = 8'h01 << sel;
    return oneHot[5:0];
  endfunction

  // Mode vectors: caught at the first edge after reset release, then held
  always_comb begin
    capture_d = 1'b0;
    mode_d = mode_q;
    if (capture_q) begin
      mode_d.triState = !intPinLvl[cmv_pkg::MV_TRISTATE];
      mode_d.byte_order_select = intPinLvl[cmv_pkg::MV_BYTE_ORDER];
      mode_d.refillInit = intPinLvl[cmv_pkg::MV_REFILL];
      mode_d.cohDmaEn = !intPinLvl[cmv_pkg::MV_COH_DMA];
      mode_d.clk1x = !intPinLvl[cmv_pkg::MV_CLK_1X];
      mode_d.halfBus = !intPinLvl[cmv_pkg::MV_HALF_BUS];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      capture_q <= 1'b1;
      mode_q <= '0;
    end else begin
      capture_q <= capture_d;
      mode_q <= mode_d;
    end
  end

  // Interrupt routing
  always_comb begin
    fpMask = fpDecode(cfg_q.fpIntSel);
    for (int i = 0; i < cmv_pkg::NUM_INT; i++) begin
      cpuIntReq[i] = fpMask[i] ? floatExcReq : !intPinLvl[i];
    end
    anyInt = |cpuIntReq;
  end

  // Configuration register
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_q.halt && anyInt) begin
      cfg_d.halt = 1'b0;
    end
    if (capture_q) begin
      cfg_d.blockRefill = intPinLvl[cmv_pkg::MV_REFILL];
    end else if (CFG_PRESENT && cfgWrEn && !cfg_q.lock) begin
      cfg_d.lock = cfgWrData[cmv_pkg::LOCK_BIT];
      cfg_d.slowBus = cfgWrData[cmv_pkg::SLOW_BUS_BIT];
      cfg_d.blockRefill = cfgWrData[cmv_pkg::REFILL_BIT];
      cfg_d.fpIntSel = cfgWrData[cmv_pkg::FLOAT_EXCEPTION_IRQ_SELECT_HI:cmv_pkg::FLOAT_EXCEPTION_IRQ_SELECT_LO];
      cfg_d.halt = cfgWrData[cmv_pkg::HALT_BIT];
      cfg_d.redFreq = cfgWrData[cmv_pkg::RED_FREQ_BIT];
      cfg_d.altCache = cfgWrData[cmv_pkg::ALT_CACHE_BIT];
    end
    rdData_d = rdData_q;
    if (cfgRdEn) begin
      rdData_d = CFG_PRESENT ? {cfg_q, cmv_pkg::RESERVED_VAL} : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= '{lock: 1'b0, slowBus: 1'b0, blockRefill: 1'b0, fpIntSel: cmv_pkg::FLOAT_EXCEPTION_IRQ_SELECT_RESET,
                 halt: 1'b0, redFreq: 1'b0, altCache: 1'b0};
      rdData_q <= 32'h00000000;
    end else begin
      cfg_q <= cfg_d;
      rdData_q <= rdData_d;
    end
  end

  // Bus turnaround pacing
  always_comb begin
    turn_d = turn_q;
    turnCnt_d = turnCnt_q;
    turnGo = 1'b0;
    unique case (turn_q)
      cmv_pkg::TURN_IDLE: begin
        if (turnReq) begin
          turn_d = cmv_pkg::TURN_WAIT;
          turnCnt_d = (cfg_q.slowBus ? cmv_pkg::TURN_SLOW_CYC : cmv_pkg::TURN_FAST_CYC) - 3'h2;
          if (turnCnt_d == 3'h0 && !cfg_q.slowBus && cmv_pkg::TURN_FAST_CYC == 3'h1) begin
            turn_d = cmv_pkg::TURN_GO;
          end
        end
      end
      cmv_pkg::TURN_WAIT: begin
        if (turnCnt_q == 3'h0) begin
          turn_d = cmv_pkg::TURN_GO;
        end else begin
          turnCnt_d = turnCnt_q - 3'h1;
        end
      end
      cmv_pkg::TURN_GO: begin
        turnGo = 1'b1;
        turn_d = cmv_pkg::TURN_IDLE;
      end
      default: begin
        turn_d = cmv_pkg::TURN_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      turn_q <= cmv_pkg::TURN_IDLE;
      turnCnt_q <= 3'h0;
    end else begin
      turn_q <= turn_d;
      turnCnt_q <= turnCnt_d;
    end
  end

  cmv_clk_div uDiv (
    .core_clk(core_clk),
    .nrst(nrst),
    .redFreq(cfg_q.redFreq),
    .halfBus(mode_q.halfBus),
    .execTick(divTick),
    .busTick(busTick),
    .boardClk(boardClk)
  );

  // Outputs
  assign execTick = divTick && !execStall;
  assign execStall = cfg_q.halt && !anyInt;
  assign coprocOneCond = floatCmpResult;
  assign refillWords = cfg_q.blockRefill ? cmv_pkg::REFILL_BLOCK : cmv_pkg::REFILL_SINGLE;
  assign cacheKb = cfg_q.altCache ? cmv_pkg::CACHE_KB_ALT : cmv_pkg::CACHE_KB_STD;
  assign cfgRdData = rdData_q;
  assign byte_order_select = mode_q.byte_order_select;
  assign cohDmaEn = mode_q.cohDmaEn;
  assign clk1x = mode_q.clk1x;
  assign halfBus = mode_q.halfBus;
  assign pinOutEn = !mode_q.triState && !capture_q;
  assign captureDone = !capture_q;

  // Assertions
  a_lock_blocks_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (cfg_q.lock && !capture_q) |=> (cfg_q.lock && cfg_q.fpIntSel == $past(cfg_q.fpIntSel)
      && cfg_q.redFreq == $past(cfg_q.redFreq) && cfg_q.slowBus == $past(cfg_q.slowBus)))
    else $error("locked configuration changed");

  a_halt_stalls: assert property (@(posedge core_clk) disable iff (!nrst)
    (cfg_q.halt && intPinLvl == 6'h3f && !floatExcReq) |-> (execStall && !execTick))
    else $error("halt did not stall execution");

  a_halt_release: assert property (@(posedge core_clk) disable iff (!nrst)
    (cfg_q.halt && anyInt && !(cfgWrEn && !cfg_q.lock)) |=> !cfg_q.halt)
    else $error("halt not released by interrupt");

  a_fp_route: assert property (@(posedge core_clk) disable iff (!nrst)
    (cfg_q.fpIntSel == 3'h3) |-> (cpuIntReq[3] == floatExcReq))
    else $error("float exception not routed to default input");

  a_refill_init: assert property (@(posedge core_clk) disable iff (!nrst)
    (nrst && capture_q) |=> (cfg_q.blockRefill == $past(intPinLvl[cmv_pkg::MV_REFILL])))
    else $error("refill bit not taken from mode vector");

  a_mode_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !capture_q |=> ($stable(mode_q) && !capture_q))
    else $error("mode vectors changed after capture");

  a_fast_turn: assert property (@(posedge core_clk) disable iff (!nrst)
    (turn_q == cmv_pkg::TURN_IDLE && turnReq && !cfg_q.slowBus) |-> !turnGo ##2 turnGo)
    else $error("fast turnaround not two cycles");

  a_slow_turn: assert property (@(posedge core_clk) disable iff (!nrst)
    (turn_q == cmv_pkg::TURN_IDLE && turnReq && cfg_q.slowBus) |-> !turnGo [*6] ##0 1'b1 ##1 turnGo)
    else $error("slow turnaround not six cycles");

  a_read_reserved: assert property (@(posedge core_clk) disable iff (!nrst)
    cfgRdEn |=> (cfgRdData[22:0] == 23'h000000))
    else $error("reserved bits read nonzero");

  a_absent_ignore: assert property (@(posedge core_clk) disable iff (!nrst)
    (!CFG_PRESENT && !capture_q) |=> (cfg_q.redFreq == 1'b0 && cfgRdData == 32'h00000000))
    else $error("absent register took a write");

  c_lock_write: cover property (@(posedge core_clk) disable iff (!nrst) cfg_q.lock && cfgWrEn);
  c_halt_wake: cover property (@(posedge core_clk) disable iff (!nrst) cfg_q.halt ##1 !cfg_q.halt);
  c_slow_turn: cover property (@(posedge core_clk) disable iff (!nrst) cfg_q.slowBus && turnGo);
  c_reduced: cover property (@(posedge core_clk) disable iff (!nrst) cfg_q.redFreq && divTick);

endmodule
`default_nettype wire

/* verification/cmv_config_top_tb.sv */
// Self-checking testbench for the configuration register and reset mode vectors.
// Assumes the design files under hw/ are compiled first; drives all ports itself.
`timescale 1ns/1ps
`default_nettype none
module cmv_config_top_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic cfgWrEn = 1'b0;
  logic cfgRdEn = 1'b0;
  logic [31:0] cfgWrData = 32'h0;
  logic [5:0] intPinLvl = 6'h27;
  logic floatExcReq = 1'b0;
  logic floatCmpResult = 1'b0;
  logic turnReq = 1'b0;
  logic turnGo, coprocOneCond, execStall, execTick, busTick, boardClk;
  logic byte_order_select, cohDmaEn, clk1x, halfBus, pinOutEn, captureDone;
  logic [31:0] cfgRdData, absRd;
  logic [5:0] cpuIntReq;
  logic [2:0] refillWords;
  logic [3:0] cacheKb, absKb;
  int errors = 0;
  int checked = 0;

  always #4 core_clk = ~core_clk;

  cmv_config_top u_dut (.core_clk(core_clk), .nrst(nrst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .intPinLvl(intPinLvl), .floatExcReq(floatExcReq),
    .floatCmpResult(floatCmpResult), .turnReq(turnReq), .turnGo(turnGo), .cpuIntReq(cpuIntReq),
    .coprocOneCond(coprocOneCond), .execStall(execStall), .execTick(execTick), .busTick(busTick),
    .boardClk(boardClk), .refillWords(refillWords), .cacheKb(cacheKb), .byte_order_select(byte_order_select),
    .cohDmaEn(cohDmaEn), .clk1x(clk1x), .halfBus(halfBus), .pinOutEn(pinOutEn), .captureDone(captureDone));

  // Variant without the register shares all inputs
  cmv_config_top #(.CFG_PRESENT(1'b0)) u_absent (.core_clk(core_clk), .nrst(nrst), .cfgWrEn(cfgWrEn),
    .cfgRdEn(cfgRdEn), .cfgWrData(cfgWrData), .cfgRdData(absRd), .intPinLvl(intPinLvl),
    .floatExcReq(floatExcReq), .floatCmpResult(floatCmpResult), .turnReq(turnReq), .turnGo(),
    .cpuIntReq(), .coprocOneCond(), .execStall(), .execTick(), .busTick(), .boardClk(),
    .refillWords(), .cacheKb(absKb), .byte_order_select(), .cohDmaEn(), .clk1x(), .halfBus(), .pinOutEn(),
    .captureDone());

  task stop_test;
    $display("Counts: %0d mismatches in %0d comparisons", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task rst(input logic [5:0] pins);
    @(posedge core_clk);
    nrst <= 1'b0;
    intPinLvl <= pins;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task wr(input logic [31:0] d);
    @(posedge core_clk);
    cfgWrEn <= 1'b1;
    cfgWrData <= d;
    @(posedge core_clk);
    cfgWrEn <= 1'b0;
    @(negedge core_clk);
  endtask

  task rd(input logic [31:0] exp);
    @(posedge core_clk);
    cfgRdEn <= 1'b1;
    @(posedge core_clk);
    cfgRdEn <= 1'b0;
    @(negedge core_clk);
    chk(cfgRdData, exp);
    chk(absRd, 32'h0);
  endtask

  task turn(input int exp);
    int n;
    n = 0;
    @(posedge core_clk);
    turnReq <= 1'b1;
    @(posedge core_clk);
    turnReq <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (turnGo !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      stop_test();
    end else begin
      chk(n, exp);
    end
  endtask

  task cnt(input int expE, input int expB);
    int e;
    int b;
    int t;
    logic last;
    e = 0;
    b = 0;
    t = 0;
    last = boardClk;
    repeat (32) begin
      @(negedge core_clk);
      if (execTick === 1'b1) e++;
      if (busTick === 1'b1) t++;
      if (boardClk !== last) b++;
      last = boardClk;
    end
    chk(e, expE);
    chk(b, expB);
    chk(t, expB);
  endtask

  initial begin
    rst(6'h27);
    chk({26'h0, pinOutEn, byte_order_select, cohDmaEn, clk1x, halfBus, captureDone}, 32'h3d);
    rd(32'h2c000000);
    @(posedge core_clk);
    intPinLvl <= 6'h3f;
    repeat (3) @(negedge core_clk);
    chk({26'h0, pinOutEn, byte_order_select, cohDmaEn, clk1x, halfBus, captureDone}, 32'h3d);
    chk(refillWords, 32'h4);
    wr(32'h00800000);
    chk({cacheKb, 1'b0, refillWords}, 32'h81);
    chk(absKb, 32'h4);
    rd(32'h00800000);
    wr(32'h2c000000);
    rd(32'h2c000000);
    chk({cacheKb, 1'b0, refillWords}, 32'h44);
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      floatCmpResult <= v[0];
      @(negedge core_clk);
      chk(coprocOneCond, v);
    end
    turn(2);
    wr(32'h4c000000);
    turn(6);
    for (int s = 0; s < 7; s++) begin
      wr({3'h0, s[2:0], 26'h0});
      @(posedge core_clk);
      intPinLvl <= 6'h00;
      floatExcReq <= 1'b0;
      @(negedge core_clk);
      chk({26'h0, cpuIntReq}, {26'h0, 6'h3f & ~(6'h1 << s[2:0])});
      @(posedge core_clk);
      floatExcReq <= 1'b1;
      @(negedge core_clk);
      chk({26'h0, cpuIntReq}, 32'h3f);
    end
    @(posedge core_clk);
    intPinLvl <= 6'h3f;
    floatExcReq <= 1'b0;
    wr(32'h0e000000);
    chk({execStall, execTick}, 32'h2);
    repeat (3) @(negedge core_clk);
    chk({execStall, execTick}, 32'h2);
    @(posedge core_clk);
    intPinLvl <= 6'h3e;
    @(negedge core_clk);
    chk(execStall, 32'h0);
    @(posedge core_clk);
    intPinLvl <= 6'h3f;
    rd(32'h0c000000);
    wr(32'h0d000000);
    cnt(2, 2);
    wr(32'h0c000000);
    cnt(32, 32);
    wr(32'h8c000000);
    wr(32'h00800000);
    rd(32'h8c000000);
    chk(cacheKb, 32'h4);
    rst(6'h18);
    chk({26'h0, pinOutEn, byte_order_select, cohDmaEn, clk1x, halfBus, captureDone}, 32'h3);
    chk(refillWords, 32'h1);
    rd(32'h0c000000);
    @(posedge core_clk);
    intPinLvl <= 6'h3f;
    @(negedge core_clk);
    cnt(32, 16);
    rst(6'h38);
    chk({26'h0, pinOutEn, byte_order_select, cohDmaEn, clk1x, halfBus, captureDone}, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
